/* File: hw/framer_pkg.sv */
package framer_pkg;
  // Bus geometry
  localparam int APB_AW = 5;
  localparam int DW = 32;

  // Register byte offsets
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] WAIT_OFS = 5'h04;
  localparam logic [4:0] LEAD_OFS = 5'h08;
  localparam logic [4:0] TRAIL_OFS = 5'h0C;
  localparam logic [4:0] CHARS_OFS = 5'h10;
  localparam logic [4:0] STAT_OFS = 5'h14;
  localparam logic [4:0] MASK_OFS = 5'h18;

  // Control field positions
  localparam int CHK_EN_BIT = 0;
  localparam int LEAD_EN_BIT = 1;
  localparam int TRAIL_EN_BIT = 2;
  localparam int SWAP_BIT = 3;
  localparam int FBUS_BIT = 4;
  localparam int ACK_MODE_BIT = 5;
  localparam int LEAD_LEN_LSB = 8;
  localparam int TRAIL_LEN_LSB = 12;

  // Protocol character field positions
  localparam int STX_LSB = 0;
  localparam int ETX_LSB = 8;
  localparam int ACK_LSB = 16;
  localparam int NAK_LSB = 24;

  // Status field positions
  localparam int ST_SENT_BIT = 0;
  localparam int ST_REPLY_BIT = 1;
  localparam int ST_TMO_BIT = 2;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_WAIT_BIT = 9;
  localparam int EVT_W = 3;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_2104;
  localparam logic [7:0] WAIT_RST = 8'h0C;
  localparam logic [31:0] LEAD_RST = 32'h0000_000D;
  localparam logic [31:0] TRAIL_RST = 32'h0000_0A0D;
  localparam logic [31:0] CHARS_RST = 32'h1506_0000;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int WAIT_STEP_US = 1000;
  localparam int STEP_CYCLES = CLK_HZ / 1_000_000 * WAIT_STEP_US;

  // Frame sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_STX, S_LEAD, S_DATA, S_TRAIL, S_ETX, S_LRC, S_WAIT
  } frame_st_t;
endpackage

/* File: hw/message_framer.sv */
`timescale 1ns/10ps
// Overview of operation
// - Host reply wait counted in one-millisecond steps, default twelve steps.
// - Wait limit 0..255; zero means wait forever for the reply.
// - Wait limit applies only in acknowledge mode with ACK, NAK, ETX enabled.
// - Check char is XOR of all chars after STX through ETX.
// - Check char appended last; host recomputes XOR and compares.
// - Check char enable bit, 0 off, 1 on, default off.
// - Enabled leading string of one to four chars precedes each message.
// - Leading string default disabled, default content carriage return.
// - Enabled trailing string of up to four chars follows each message.
// - Trailing string default enabled, default content CR then LF.
// - Byte swap setting for fieldbus decode data, default off.
// - Text fields accept any byte value 00 through FF.
// - Empty fields of a setting keep their current value.
// - Order: STX, leading, data, trailing, ETX, check char.
// - Check covers leading, trailing and ETX but never STX.
// - ACK default 06, NAK default 15, both configurable.
module message_framer #(
  parameter int STEP_CYCLES = framer_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [framer_pkg::APB_AW-1:0] paddr,
  input wire logic [framer_pkg::DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [framer_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded message in
  input wire logic msg_valid,
  input wire logic [7:0] msg_data,
  input wire logic msg_last,
  output logic msg_ready,
  // Characters to host serial port
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Host reply from protocol controller
  input wire logic host_reply,
  output logic reply_timeout,
  // Fieldbus settings
  output logic byte_swap_cmd,
  output logic fieldbus_enable_cmd,
  // Interrupt
  output logic irq
);
  import framer_pkg::*;

  if (STEP_CYCLES < 1) begin : g_chk
    $error("STEP_CYCLES must be at least one");
  end

  // Byte of a word by index
  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] i);
    pick = w[{i, 3'b000} +: 8];
  endfunction

  // Strobed merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Clamp a string length into 1..4 or 0..4
  function automatic logic [2:0] clamp_len(input logic [2:0] raw, input logic min1);
    if (raw > 3'd4) begin
      clamp_len = 3'd4;
    end else if (min1 && raw == 3'd0) begin
      clamp_len = 3'd1;
    end else begin
      clamp_len = raw;
    end
  endfunction

  // Registers
  logic [31:0] ctrl_q;
  logic [7:0] wait_q;
  logic [31:0] lead_q;
  logic [31:0] trail_q;
  logic [31:0] chars_q;
  logic [EVT_W-1:0] stat_q;
  logic [EVT_W-1:0] mask_q;

  // Bus decode
  logic acc;
  logic wr;
  logic rd;
  logic hit;

  assign acc = psel && penable;
  assign hit = (paddr == CTRL_OFS) || (paddr == WAIT_OFS) ||
               (paddr == LEAD_OFS) || (paddr == TRAIL_OFS) ||
               (paddr == CHARS_OFS) || (paddr == STAT_OFS) ||
               (paddr == MASK_OFS);
  assign wr = acc && pwrite && hit;
  assign rd = acc && !pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // Decoded settings
  logic chk_en;
  logic lead_en;
  logic trail_en;
  logic ack_mode;
  logic [2:0] lead_len;
  logic [2:0] trail_len;
  logic [7:0] stx_ch;
  logic [7:0] etx_ch;
  logic [7:0] ack_ch;
  logic [7:0] nak_ch;

  assign chk_en = ctrl_q[CHK_EN_BIT];
  assign lead_en = ctrl_q[LEAD_EN_BIT];
  assign trail_en = ctrl_q[TRAIL_EN_BIT];
  assign ack_mode = ctrl_q[ACK_MODE_BIT];
  assign lead_len = clamp_len(ctrl_q[LEAD_LEN_LSB +: 3], 1'b1);
  assign trail_len = clamp_len(ctrl_q[TRAIL_LEN_LSB +: 3], 1'b0);
  assign stx_ch = chars_q[STX_LSB +: 8];
  assign etx_ch = chars_q[ETX_LSB +: 8];
  assign ack_ch = chars_q[ACK_LSB +: 8];
  assign nak_ch = chars_q[NAK_LSB +: 8];
  assign byte_swap_cmd = ctrl_q[SWAP_BIT];
  assign fieldbus_enable_cmd = ctrl_q[FBUS_BIT];

  // Setting registers; unstrobed lanes keep their value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      wait_q <= WAIT_RST;
      lead_q <= LEAD_RST;
      trail_q <= TRAIL_RST;
      chars_q <= CHARS_RST;
      mask_q <= MASK_RST;
    end else if (wr) begin
      unique case (paddr)
        CTRL_OFS: ctrl_q <= merge(ctrl_q, pwdata, pstrb);
        WAIT_OFS: begin
          if (pstrb[0]) begin
            wait_q <= pwdata[7:0];
          end
        end
        LEAD_OFS: lead_q <= merge(lead_q, pwdata, pstrb);
        TRAIL_OFS: trail_q <= merge(trail_q, pwdata, pstrb);
        CHARS_OFS: chars_q <= merge(chars_q, pwdata, pstrb);
        MASK_OFS: begin
          if (pstrb[0]) begin
            mask_q <= pwdata[EVT_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Frame sequencer state
  frame_st_t st_q;
  frame_st_t st_d;
  logic [1:0] idx_q;
  logic [7:0] lrc_q;
  logic out_v_q;
  logic [7:0] out_d_q;
  logic free;
  logic emit;
  logic [7:0] emit_ch;
  logic seg_end;
  logic wait_need;
  logic stx_on;
  logic etx_on;
  logic trail_on;
  frame_st_t after_trail;
  frame_st_t after_etx;
  frame_st_t done_st;
  logic tmo;

  assign free = !out_v_q || tx_ready;
  assign stx_on = stx_ch != 8'h00;
  assign etx_on = etx_ch != 8'h00;
  assign trail_on = trail_en && (trail_len != 3'd0);
  assign wait_need = ack_mode && etx_on && (ack_ch != 8'h00) &&
                     (nak_ch != 8'h00);
  assign done_st = wait_need ? S_WAIT : S_IDLE;
  assign after_etx = chk_en ? S_LRC : done_st;
  assign after_trail = etx_on ? S_ETX : after_etx;
  assign msg_ready = (st_q == S_DATA) && free;
  assign tx_valid = out_v_q;
  assign tx_data = out_d_q;

  // Character offered in the current state
  always_comb begin
    emit = 1'b0;
    emit_ch = 8'h00;
    seg_end = 1'b1;
    unique case (st_q)
      S_STX: begin
        emit = free;
        emit_ch = stx_ch;
      end
      S_LEAD: begin
        emit = free;
        emit_ch = pick(lead_q, idx_q);
        seg_end = {1'b0, idx_q} == lead_len - 3'd1;
      end
      S_DATA: begin
        emit = free && msg_valid;
        emit_ch = msg_data;
        seg_end = msg_last;
      end
      S_TRAIL: begin
        emit = free;
        emit_ch = pick(trail_q, idx_q);
        seg_end = {1'b0, idx_q} == trail_len - 3'd1;
      end
      S_ETX: begin
        emit = free;
        emit_ch = etx_ch;
      end
      S_LRC: begin
        emit = free;
        emit_ch = lrc_q;
      end
      S_IDLE, S_WAIT: ;
    endcase
  end

  // Next state in transmit order
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: begin
        if (msg_valid) begin
          st_d = stx_on ? S_STX : (lead_en ? S_LEAD : S_DATA);
        end
      end
      S_STX: if (emit) st_d = lead_en ? S_LEAD : S_DATA;
      S_LEAD: if (emit && seg_end) st_d = S_DATA;
      S_DATA: begin
        if (emit && seg_end) begin
          st_d = trail_on ? S_TRAIL : after_trail;
        end
      end
      S_TRAIL: if (emit && seg_end) st_d = after_trail;
      S_ETX: if (emit) st_d = after_etx;
      S_LRC: if (emit) st_d = done_st;
      S_WAIT: if (host_reply || tmo) st_d = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Index within leading and trailing strings
  always_ff @(posedge clk) begin
    if (!rst_n || st_d != st_q) begin
      idx_q <= 2'd0;
    end else if (emit) begin
      idx_q <= idx_q + 2'd1;
    end
  end

  // Running XOR of every char after STX up to the check char
  always_ff @(posedge clk) begin
    if (!rst_n || st_q == S_IDLE) begin
      lrc_q <= 8'h00;
    end else if (emit && st_q != S_STX && st_q != S_LRC) begin
      lrc_q <= lrc_q ^ emit_ch;
    end
  end

  // One-character output register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_v_q <= 1'b0;
      out_d_q <= 8'h00;
    end else if (emit) begin
      out_v_q <= 1'b1;
      out_d_q <= emit_ch;
    end else if (tx_ready) begin
      out_v_q <= 1'b0;
    end
  end

  // Host reply wait timer
  logic wait_start;

  assign wait_start = (st_q != S_WAIT) && (st_d == S_WAIT);

  reply_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(wait_start),
    .stop(host_reply && st_q == S_WAIT),
    .limit(wait_q),
    .timeout(tmo)
  );

  assign reply_timeout = tmo && st_q == S_WAIT;

  // Sticky events; a read clears only the bits it reported, a new event wins
  logic [EVT_W-1:0] evt;

  assign evt[ST_SENT_BIT] = (st_q != S_IDLE) && (st_q != S_WAIT) &&
                            (st_d == S_IDLE || st_d == S_WAIT);
  assign evt[ST_REPLY_BIT] = host_reply && st_q == S_WAIT;
  assign evt[ST_TMO_BIT] = reply_timeout;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else if (rd && paddr == STAT_OFS) begin
      stat_q <= (stat_q & ~prdata[EVT_W-1:0]) | evt;
    end else begin
      stat_q <= stat_q | evt;
    end
  end

  // Interrupt level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      unique case (paddr)
        CTRL_OFS: prdata <= ctrl_q;
        WAIT_OFS: prdata <= {24'h0, wait_q};
        LEAD_OFS: prdata <= lead_q;
        TRAIL_OFS: prdata <= trail_q;
        CHARS_OFS: prdata <= chars_q;
        STAT_OFS: begin
          prdata[EVT_W-1:0] <= stat_q;
          prdata[ST_BUSY_BIT] <= st_q != S_IDLE;
          prdata[ST_WAIT_BIT] <= st_q == S_WAIT;
        end
        MASK_OFS: prdata[EVT_W-1:0] <= mask_q;
        default: ;
      endcase
    end
  end
endmodule

/* File: hw/reply_timer.sv */
`timescale 1ns/10ps
module reply_timer #(
  parameter int STEP_CYCLES = framer_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [7:0] limit,
  // Result
  output logic timeout
);
  import framer_pkg::*;

  localparam int PW = $clog2(STEP_CYCLES + 1);

  if (STEP_CYCLES < 1) begin : g_chk
    $error("STEP_CYCLES must be at least one");
  end

  logic run_q;
  logic [PW-1:0] pre_q;
  logic [7:0] steps_q;
  logic [7:0] lim_q;
  logic tick;
  logic expire;

  // One-cycle enable every millisecond step
  assign tick = run_q && (pre_q == PW'(STEP_CYCLES - 1));
  assign expire = tick && (lim_q != 8'h00) && (steps_q == lim_q - 8'h01);

  // Run flag and latched limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      lim_q <= 8'h00;
    end else if (start) begin
      run_q <= 1'b1;
      lim_q <= limit;
    end else if (stop || expire) begin
      run_q <= 1'b0;
    end
  end

  // Step divider and step counter, cleared on start and expiry
  always_ff @(posedge clk) begin
    if (!rst_n || start || expire || !run_q) begin
      pre_q <= '0;
      steps_q <= 8'h00;
    end else if (tick) begin
      pre_q <= '0;
      if (lim_q != 8'h00) begin
        steps_q <= steps_q + 8'h01;
      end
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // Single-cycle expiry pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timeout <= 1'b0;
    end else begin
      timeout <= expire && !stop;
    end
  end
endmodule

/* File: testbench/framer_props.sv */
`timescale 1ns/10ps
module framer_props import framer_pkg::*; #(
  parameter int STEP_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [framer_pkg::APB_AW-1:0] paddr,
  input wire logic [framer_pkg::DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [framer_pkg::DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Streams and settings
  input wire logic msg_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic reply_timeout,
  input wire logic byte_swap_cmd,
  input wire logic fieldbus_enable_cmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] wait_q;
  int gap_q;
  logic ctrl_wr;
  // Control register write seen on the bus
  assign ctrl_wr = psel && penable && pwrite && paddr == CTRL_OFS && pstrb[0];
  // Shadow of the wait limit
  always_ff @(posedge clk) begin
    if (!rst_n)
      wait_q <= WAIT_RST;
    else if (psel && penable && pwrite && paddr == WAIT_OFS && pstrb[0])
      wait_q <= pwdata[7:0];
  end
  // Cycles since the last character left
  always_ff @(posedge clk) begin
    if (!rst_n || (tx_valid && tx_ready))
      gap_q <= 0;
    else
      gap_q <= gap_q + 1;
  end
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stalled character dropped or changed");
  a_tmo_pulse: assert property (reply_timeout |=> !reply_timeout)
    else $error("timeout longer than one cycle");
  a_tmo_quiet: assert property (reply_timeout |-> !tx_valid && !msg_ready)
    else $error("timeout outside the reply wait");
  a_tmo_floor: assert property (reply_timeout |-> gap_q + 1 >= wait_q * STEP_CYCLES)
    else $error("timeout came before the wait limit");
  a_tmo_zero: assert property (reply_timeout |-> wait_q != 8'h00)
    else $error("timeout with a zero wait limit");
  a_swap_src: assert property ($changed(byte_swap_cmd) |->
    $past(ctrl_wr) && byte_swap_cmd == $past(pwdata[SWAP_BIT]))
    else $error("byte swap changed without a control write");
  a_fbus_src: assert property ($changed(fieldbus_enable_cmd) |->
    $past(ctrl_wr) && fieldbus_enable_cmd == $past(pwdata[FBUS_BIT]))
    else $error("fieldbus enable changed without a control write");
  a_apb_answer: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pready && pslverr == (paddr > 5'h18))
    else $error("bus answer or error flag wrong");
  a_read_refuse: assert property (psel && penable && !pwrite && paddr > 5'h18 |-> prdata == 32'h0)
    else $error("unmapped read returned data");
endmodule
bind message_framer framer_props #(
  .STEP_CYCLES(STEP_CYCLES)
) props (
  .clk(clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .msg_ready(msg_ready),
  .tx_valid(tx_valid),
  .tx_data(tx_data),
  .tx_ready(tx_ready),
  .reply_timeout(reply_timeout),
  .byte_swap_cmd(byte_swap_cmd),
  .fieldbus_enable_cmd(fieldbus_enable_cmd)
);

/* File: testbench/host_model.sv */
`timescale 1ns/10ps
module host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial characters
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Reply control
  input wire logic slow,
  input wire logic answer,
  output logic host_reply
);
  logic [7:0] rx_q[$];
  int tick_q = 0;
  int quiet_q = 0;
  // Take characters, stalling every other cycle when slow
  always @(posedge clk) begin
    tick_q <= tick_q + 1;
    tx_ready <= rst_n && (!slow || tick_q[0]);
    if (tx_valid && tx_ready)
      rx_q.push_back(tx_data);
  end
  // Reply some quiet cycles after the last character
  always @(posedge clk) begin
    quiet_q <= (tx_valid || !rst_n) ? 0 : quiet_q + 1;
    host_reply <= rst_n && answer && quiet_q % 16 == 6;
  end
endmodule

/* File: testbench/message_framer_bench.sv */
`timescale 1ns/10ps
module message_framer_bench;
  import framer_pkg::*;
  localparam int STEP = 4;
  logic clk = '0;
  logic rst_n = '0;
  logic psel = '0, penable = '0, pwrite = '0, msg_valid = '0, msg_last = '0;
  logic slow = '0, answer = '0, e;
  logic [4:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, ctrl, lead, trail, chars;
  logic [3:0] pstrb = '0;
  logic [7:0] msg_data = '0, tx_data, x;
  logic pready, pslverr, msg_ready, tx_valid, tx_ready, host_reply, reply_timeout, swap, fbus, irq;
  logic [7:0] exp_q[$];
  int fail_count = 0, samples_checked = 0, cyc = 0, tmo_n = 0;
  logic [4:0] ra[6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18};
  logic [31:0] rv[6] = '{32'h2104, 32'h0C, 32'h0D, 32'h0A0D, 32'h1506_0000, 32'h0};
  int wl[4] = '{2, 255, 0, 1};
  logic [7:0] el[4] = '{8'h03, 8'h03, 8'h03, 8'h00};
  logic al[4] = '{1'h0, 1'h1, 1'h0, 1'h0};
  message_framer #(.STEP_CYCLES(STEP)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
    .msg_data(msg_data), .msg_last(msg_last), .msg_ready(msg_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .host_reply(host_reply),
    .reply_timeout(reply_timeout), .byte_swap_cmd(swap), .fieldbus_enable_cmd(fbus), .irq(irq));
  host_model host (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .slow(slow), .answer(answer), .host_reply(host_reply));
  // Clock
  initial forever #2 clk = ~clk;
  // Timeout counts and hang guard
  always @(posedge clk) begin
    cyc++;
    if (reply_timeout === 1'h1)
      tmo_n++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // One bus transfer; read data and error land in r and e
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic put(input logic [7:0] b);
    exp_q.push_back(b);
    x ^= b;
  endtask
  // Reference frame, message drive and comparison
  task automatic run_frame(input int n);
    int k;
    logic [7:0] d[$];
    exp_q.delete();
    x = 8'h00;
    if (chars[7:0] != 8'h00)
      exp_q.push_back(chars[7:0]);
    k = ctrl[10:8] == 3'h0 ? 1 : (ctrl[10:8] > 3'h4 ? 4 : int'(ctrl[10:8]));
    if (ctrl[1])
      for (int i = 0; i < k; i++) put(lead[8*i+:8]);
    for (int i = 0; i < n; i++) d.push_back(8'($urandom));
    foreach (d[i]) put(d[i]);
    k = ctrl[14:12] > 3'h4 ? 4 : int'(ctrl[14:12]);
    if (ctrl[2])
      for (int i = 0; i < k; i++) put(trail[8*i+:8]);
    if (chars[15:8] != 8'h00)
      put(chars[15:8]);
    if (ctrl[0])
      exp_q.push_back(x);
    foreach (d[i]) begin
      msg_valid <= 1'h1;
      msg_data <= d[i];
      msg_last <= (i == n - 1);
      @(posedge clk);
      while (msg_ready !== 1'h1) @(posedge clk);
    end
    msg_valid <= 1'h0;
    for (int i = 0; i < 300 && host.rx_q.size() < exp_q.size(); i++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk("frame length", host.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) chk("frame char", host.rx_q[i], exp_q[i]);
    host.rx_q.delete();
  endtask
  initial begin
    void'($urandom(32'h672aa4a4));
    ctrl = 32'h2104;
    lead = 32'h0D;
    trail = 32'h0A0D;
    chars = 32'h1506_0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    foreach (ra[i]) begin
      apb(1'h0, ra[i], 32'h0, 4'h0);
      chk("reset value", r, rv[i]);
    end
    // Random framings, first one with reset settings
    for (int t = 0; t < 12; t++) begin
      slow <= t[1];
      run_frame(1 + $urandom % 5);
      chk("byte swap", swap, ctrl[3]);
      chk("fieldbus", fbus, ctrl[4]);
      ctrl = $urandom & 32'h771F;
      lead = $urandom;
      trail = $urandom;
      chars = {16'h1506, 8'($urandom), t[0] ? 8'($urandom) : 8'h00};
      apb(1'h1, 5'h00, ctrl, 4'hF);
      apb(1'h1, 5'h08, lead, 4'hF);
      apb(1'h1, 5'h0C, trail, 4'hF);
      apb(1'h1, 5'h10, chars, 4'hF);
    end
    // Partial field update keeps untouched bytes
    apb(1'h1, 5'h08, 32'h2C3E_3C41, 4'hF);
    apb(1'h1, 5'h08, 32'h1122_3344, 4'h4);
    apb(1'h0, 5'h08, 32'h0, 4'h0);
    chk("lead partial", r, 32'h2C22_3C41);
    apb(1'h0, 5'h1C, 32'h0, 4'h0);
    chk("unmapped err", e, 1'h1);
    chk("unmapped data", r, 32'h0);
    // Interrupt raise and clear on frame sent
    apb(1'h1, 5'h18, 32'h1, 4'hF);
    repeat (3) @(posedge clk);
    chk("irq set", irq, 1'h1);
    apb(1'h0, 5'h14, 32'h0, 4'h0);
    chk("status", r[2:0], 3'h1);
    repeat (3) @(posedge clk);
    chk("irq clear", irq, 1'h0);
    apb(1'h1, 5'h18, 32'h4, 4'hF);
    // Reply wait cases; host takes every character so the wait floor is exact
    slow <= 1'h0;
    for (int c = 0; c < 4; c++) begin
      ctrl = 32'h2124;
      chars = {16'h1506, el[c], 8'h02};
      apb(1'h1, 5'h04, wl[c], 4'hF);
      apb(1'h1, 5'h00, ctrl, 4'hF);
      apb(1'h1, 5'h10, chars, 4'hF);
      apb(1'h0, 5'h14, 32'h0, 4'h0);
      answer <= al[c];
      tmo_n = 0;
      run_frame(3);
      repeat (wl[c] * STEP + 20) @(posedge clk);
      chk("timeouts", tmo_n, wl[c] != 0 && el[c] != 8'h00 && !al[c]);
      chk("irq timeout", irq, wl[c] != 0 && el[c] != 8'h00 && !al[c]);
      answer <= 1'h1;
      repeat (20) @(posedge clk);
      answer <= 1'h0;
      apb(1'h0, 5'h14, 32'h0, 4'h0);
      chk("reply seen", r[1], el[c] != 8'h00 && (al[c] || wl[c] == 0));
    end
    complete_run();
  end
endmodule
